// [txrx_ctrl_pkg.sv]
`default_nettype none
package txrx_ctrl_pkg;
    localparam logic [7:0] ADDR_TX_IRQ_MASK = 8'h0b;
    localparam logic [7:0] ADDR_TX_IRQ_MODE = 8'h0c;
    localparam logic [7:0] ADDR_RX_CTRL_ONE = 8'h0d;
    localparam logic [1:0] TRIG_RISE        = 2'h0;
    localparam logic [1:0] TRIG_FALL        = 2'h1;
    localparam logic [1:0] TRIG_LEVEL       = 2'h2;
    localparam logic [1:0] RX_SEL_ONE       = 2'h0;
    localparam logic [1:0] RX_SEL_TWO       = 2'h1;
    localparam logic [1:0] RX_SEL_THREE     = 2'h2;
    localparam logic [7:0] READ_ZERO        = 8'h00;
    localparam logic [1:0] RX_SEL_FOUR      = 2'h3;
    localparam int         MASK_MSB         = 1;
    localparam int         MODE_MSB         = 3;
    localparam int         RXC_DIS_BIT      = 4;
    localparam int         RXC_CLK_BIT      = 3;
    localparam int         RXC_SEL_MSB      = 1;
    localparam logic       INT_IDLE         = 1'b1;
    localparam logic       XEN_RESET        = 1'b1;

    typedef struct packed {
        logic       slip_irq_enable;
        logic       xfer_irq_enable;
    } irq_mask_t;

    typedef struct packed {
        logic [1:0] slip_irq_trigger_sel;
        logic [1:0] xfer_irq_trigger_sel;
    } irq_mode_t;

    typedef struct packed {
        logic       rx_buffer_xfer_disable;
        logic       rx_ref_clock_select;
        logic [1:0] rx_input_select;
    } rx_ctrl_t;

    localparam irq_mask_t MASK_RESET = '{1'b0, 1'b0};
    localparam irq_mode_t MODE_RESET = '{TRIG_RISE, TRIG_RISE};
    localparam rx_ctrl_t  RXC_RESET  = '{1'b0, 1'b0, RX_SEL_ONE};
endpackage
`default_nettype wire

// [irq_trigger.sv]
`default_nettype none
module irq_trigger
    import txrx_ctrl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       raw,
    input  wire logic [1:0] sel,
    output logic            event_out
);
    logic prev_q;
    logic prev_d;
    logic ev_q;
    logic ev_d;

    // edge modes compare against previous cycle; reserved code never fires
    always_comb begin
        prev_d = raw;
        unique case (sel)
            TRIG_RISE:  ev_d = raw & ~prev_q;
            TRIG_FALL:  ev_d = ~raw & prev_q;
            TRIG_LEVEL: ev_d = raw;
            default:    ev_d = 1'b0;
        endcase
    end

    // previous-cycle copy and registered event
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            ev_q   <= 1'b0;
        end else begin
            prev_q <= prev_d;
            ev_q   <= ev_d;
        end
    end

    assign event_out = ev_q;
endmodule // irq_trigger
`default_nettype wire

// [tx_irq_mode_rx_input_regs.sv]
`default_nettype none
// Operation
// - the slip interrupt enable masks the slip interrupt when clear, passes it when set, reset clear.
// - trigger-mode register holds slip select in 3:2, transfer select in 1:0, upper bits read zero.
// - transfer trigger select 00 rising, 01 falling, 10 level, 11 reserved.
// - slip trigger select 00 rising, 01 falling, 10 level, 11 reserved.
// - input select 00..11 routes line input one to four into the receiver core.
// - the reference clock select chooses the recovery pll reference source.
// - receiver control one holds disable at 4, clock select at 3, input select 1:0, rest zero.
// - the transfer disable bit stops access-to-user buffer copies when set.
// - an unmasked slip event sets its flag, pulls the interrupt low and sets the summary bit.
module tx_irq_mode_rx_input_regs
    import txrx_ctrl_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RST_N,
    input  wire logic       WR_EN,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WR_DATA,
    output logic      [7:0] RD_DATA,
    input  wire logic       SLIP_RAW,
    input  wire logic       XFER_RAW,
    input  wire logic       FLAG_CLR,
    input  wire logic [3:0] LINE_IN,
    output logic            RX_CORE_DATA,
    output logic            RX_REF_CLK_SEL,
    output logic            RX_XFER_ENABLE,
    output logic            SOURCE_SLIP_FLAG,
    output logic            BUFFER_XFER_DONE_FLAG,
    output logic            TX_SUMMARY,
    output logic            INT_N
);
    // register bank
    irq_mask_t  mask_q,    mask_d;
    irq_mode_t  mode_q,    mode_d;
    rx_ctrl_t   rxc_q,     rxc_d;
    logic [7:0] rd_q,      rd_d;

    // interrupt flags and pin
    logic       slip_f_q,  slip_f_d;
    logic       xfer_f_q,  xfer_f_d;
    logic       int_n_q,   int_n_d;
    logic       sum_q,     sum_d;

    // receiver side outputs
    logic       mux_q,     mux_d;
    logic       ref_q,     ref_d;
    logic       xen_q,     xen_d;

    // synchroniser stages for the pin inputs
    logic [1:0] slip_s_q,  slip_s_d;
    logic [1:0] xfer_s_q,  xfer_s_d;
    logic [3:0] line_s1_q, line_s1_d;
    logic [3:0] line_s2_q, line_s2_d;

    // trigger events from the two detectors; one cycle in edge modes, held while the raw is high in level mode
    logic       slip_ev,   xfer_ev;

    // read mux: reserved bits and unmapped places return zero
    function automatic logic [7:0] read_mux(input logic [7:0] a, input irq_mask_t m,
                                            input irq_mode_t o, input rx_ctrl_t r);
        unique case (a)
            ADDR_TX_IRQ_MASK: read_mux = {6'h00, m};
            ADDR_TX_IRQ_MODE: read_mux = {4'h0, o};
            ADDR_RX_CTRL_ONE: begin
                read_mux                = READ_ZERO;
                read_mux[RXC_DIS_BIT]   = r.rx_buffer_xfer_disable;
                read_mux[RXC_CLK_BIT]   = r.rx_ref_clock_select;
                read_mux[RXC_SEL_MSB:0] = r.rx_input_select;
            end
            default:          read_mux = READ_ZERO;
        endcase
    endfunction

    // pin inputs pass two flops; the first stage feeds only the second,
    // so a metastable first stage never reaches the trigger or mux logic
    always_comb begin
        slip_s_d  = {slip_s_q[0], SLIP_RAW};
        xfer_s_d  = {xfer_s_q[0], XFER_RAW};
        line_s1_d = LINE_IN;
        line_s2_d = line_s1_q;
    end

    // synchroniser registers; zero reset matches the idle level of the raws
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            slip_s_q  <= 2'h0;
            xfer_s_q  <= 2'h0;
            line_s1_q <= 4'h0;
            line_s2_q <= 4'h0;
        end else begin
            slip_s_q  <= slip_s_d;
            xfer_s_q  <= xfer_s_d;
            line_s1_q <= line_s1_d;
            line_s2_q <= line_s2_d;
        end
    end

    // slip condition trigger, mode taken from the upper select pair
    irq_trigger u_slip_trig (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .raw       (slip_s_q[1]),
        .sel       (mode_q.slip_irq_trigger_sel),
        .event_out (slip_ev)
    );

    // buffer-transfer condition trigger, mode taken from the lower select pair
    irq_trigger u_xfer_trig (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .raw       (xfer_s_q[1]),
        .sel       (mode_q.xfer_irq_trigger_sel),
        .event_out (xfer_ev)
    );

    // register bank: a write lands at the edge that samples WR_EN
    always_comb begin
        mask_d = mask_q;
        mode_d = mode_q;
        rxc_d  = rxc_q;
        if (WR_EN) begin
            unique case (ADDR)
                ADDR_TX_IRQ_MASK: mask_d = irq_mask_t'(WR_DATA[MASK_MSB:0]);
                ADDR_TX_IRQ_MODE: mode_d = irq_mode_t'(WR_DATA[MODE_MSB:0]);
                ADDR_RX_CTRL_ONE: begin
                    // reserved bit and top bits are dropped here, so they read zero
                    rxc_d.rx_buffer_xfer_disable = WR_DATA[RXC_DIS_BIT];
                    rxc_d.rx_ref_clock_select    = WR_DATA[RXC_CLK_BIT];
                    rxc_d.rx_input_select        = WR_DATA[RXC_SEL_MSB:0];
                end
                default: ; // unmapped writes are ignored
            endcase
        end
    end

    // register bank flops; everything starts at its documented default
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mask_q <= MASK_RESET;
            mode_q <= MODE_RESET;
            rxc_q  <= RXC_RESET;
        end else begin
            mask_q <= mask_d;
            mode_q <= mode_d;
            rxc_q  <= rxc_d;
        end
    end

    // read data is registered, so it shows the state before a same-cycle write
    always_comb begin
        rd_d = read_mux(ADDR, mask_q, mode_q, rxc_q);
    end

    // read data flop
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rd_q <= READ_ZERO;
        end else begin
            rd_q <= rd_d;
        end
    end

    // sticky flags; set beats clear so an event in the clear cycle is kept
    always_comb begin
        slip_f_d = (slip_f_q & ~FLAG_CLR) | (slip_ev & mask_q.slip_irq_enable);
        xfer_f_d = (xfer_f_q & ~FLAG_CLR) | (xfer_ev & mask_q.xfer_irq_enable);
        // summary and pin follow the next flag values so all three move together
        sum_d    = slip_f_d | xfer_f_d;
        int_n_d  = ~sum_d;
    end

    // flag flops; the interrupt pin rests high out of reset
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            slip_f_q <= 1'b0;
            xfer_f_q <= 1'b0;
            sum_q    <= 1'b0;
            int_n_q  <= INT_IDLE;
        end else begin
            slip_f_q <= slip_f_d;
            xfer_f_q <= xfer_f_d;
            sum_q    <= sum_d;
            int_n_q  <= int_n_d;
        end
    end

    // input mux picks one line receiver after synchronising; one flop of
    // latency is traded for an output that never glitches on a select change
    always_comb begin
        unique case (rxc_q.rx_input_select)
            RX_SEL_ONE:   mux_d = line_s2_q[0];
            RX_SEL_TWO:   mux_d = line_s2_q[1];
            RX_SEL_THREE: mux_d = line_s2_q[2];
            RX_SEL_FOUR:  mux_d = line_s2_q[3];
        endcase
        ref_d = rxc_q.rx_ref_clock_select;
        // disable set stops the copies; the pin carries the enable sense
        xen_d = ~rxc_q.rx_buffer_xfer_disable;
    end

    // receiver output flops; buffer copies are allowed out of reset
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mux_q <= 1'b0;
            ref_q <= 1'b0;
            xen_q <= XEN_RESET;
        end else begin
            mux_q <= mux_d;
            ref_q <= ref_d;
            xen_q <= xen_d;
        end
    end

    // every output comes straight from its flop
    assign RD_DATA               = rd_q;
    assign SOURCE_SLIP_FLAG      = slip_f_q;
    assign BUFFER_XFER_DONE_FLAG = xfer_f_q;
    assign TX_SUMMARY            = sum_q;
    assign INT_N                 = int_n_q;
    assign RX_CORE_DATA          = mux_q;
    assign RX_REF_CLK_SEL        = ref_q;
    assign RX_XFER_ENABLE        = xen_q;
endmodule // tx_irq_mode_rx_input_regs
`default_nettype wire

// [ctl_checker.sv]
`default_nettype none
module ctl_checker
    import txrx_ctrl_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       RST_N,
    input wire logic       WR_EN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic [7:0] RD_DATA,
    input wire logic       SLIP_RAW,
    input wire logic       XFER_RAW,
    input wire logic       FLAG_CLR,
    input wire logic       RX_REF_CLK_SEL,
    input wire logic       RX_XFER_ENABLE,
    input wire logic       SOURCE_SLIP_FLAG,
    input wire logic       BUFFER_XFER_DONE_FLAG,
    input wire logic       TX_SUMMARY,
    input wire logic       INT_N
);
    logic [1:0] m_q;
    logic [3:0] t_q;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // shadow of mask and mode, so event checks know the setup
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            m_q <= 2'h0;
            t_q <= 4'h0;
        end else if (WR_EN && ADDR == ADDR_TX_IRQ_MASK) begin
            m_q <= WR_DATA[1:0];
        end else if (WR_EN && ADDR == ADDR_TX_IRQ_MODE) begin
            t_q <= WR_DATA[3:0];
        end
    end
    AST_INT: assert property (INT_N == !TX_SUMMARY)
        else $error("interrupt pin disagrees with summary");
    AST_MODE_RD: assert property ($past(ADDR) == ADDR_TX_IRQ_MODE |-> RD_DATA[7:4] == 4'h0)
        else $error("mode upper bits not zero");
    AST_RXC_RD: assert property ($past(ADDR) == ADDR_RX_CTRL_ONE |->
        RD_DATA[7:5] == 3'h0 && !RD_DATA[2]) else $error("rx ctrl zero bits set");
    AST_RXC_OUT: assert property (WR_EN && ADDR == ADDR_RX_CTRL_ONE |-> ##2
        RX_XFER_ENABLE == !$past(WR_DATA[4], 2) && RX_REF_CLK_SEL == $past(WR_DATA[3], 2))
        else $error("rx ctrl outputs wrong");
    AST_SLIP_RISE: assert property (m_q[1] && t_q[3:2] == 2'h0 && $rose(SLIP_RAW) |->
        ##4 SOURCE_SLIP_FLAG) else $error("rising slip missed");
    AST_XFER_FALL: assert property (m_q[0] && t_q[1:0] == 2'h1 && $fell(XFER_RAW) |->
        ##4 BUFFER_XFER_DONE_FLAG) else $error("falling transfer missed");
    AST_SLIP_MASK: assert property ($rose(SOURCE_SLIP_FLAG) |-> $past(m_q[1]))
        else $error("masked slip set flag");
    AST_STICKY: assert property (SOURCE_SLIP_FLAG && !FLAG_CLR |=> SOURCE_SLIP_FLAG)
        else $error("slip flag dropped");
    cover property ($rose(SOURCE_SLIP_FLAG));
    cover property ($rose(BUFFER_XFER_DONE_FLAG));
    cover property (WR_EN && ADDR == ADDR_RX_CTRL_ONE);
endmodule // ctl_checker
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top
    import txrx_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       REF_CLK = 0, RST_N = 0, WR_EN = 0, SLIP_RAW = 0, XFER_RAW = 0, FLAG_CLR = 0;
    logic [7:0] ADDR = 8'h00, WR_DATA = 8'h00, RD_DATA, a, d;
    logic [3:0] LINE_IN = 4'h0;
    logic       RX_CORE_DATA, RX_REF_CLK_SEL, RX_XFER_ENABLE, INT_N, TX_SUMMARY;
    logic       SOURCE_SLIP_FLAG, BUFFER_XFER_DONE_FLAG;
    int         err_total = 0, n_checks = 0, m;
    always #2 REF_CLK = ~REF_CLK;
    tx_irq_mode_rx_input_regs dut_u (.REF_CLK, .RST_N, .WR_EN, .ADDR, .WR_DATA, .RD_DATA,
        .SLIP_RAW, .XFER_RAW, .FLAG_CLR, .LINE_IN, .RX_CORE_DATA, .RX_REF_CLK_SEL,
        .RX_XFER_ENABLE, .SOURCE_SLIP_FLAG, .BUFFER_XFER_DONE_FLAG, .TX_SUMMARY, .INT_N);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // settle one ns past the edge so registered outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
        @(posedge REF_CLK);
        WR_EN <= 1'b1;
        ADDR <= wa;
        WR_DATA <= wd;
        @(posedge REF_CLK);
        WR_EN <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ra, input logic [7:0] e);
        @(posedge REF_CLK);
        ADDR <= ra;
        step(1);
        chk(RD_DATA, e);
    endtask
    // reserved bits and unmapped places read back as zero
    function automatic logic [7:0] rd_exp(input logic [7:0] fa, input logic [7:0] fd);
        case (fa)
            ADDR_TX_IRQ_MASK: return fd & 8'h03;
            ADDR_TX_IRQ_MODE: return fd & 8'h0f;
            ADDR_RX_CTRL_ONE: return fd & 8'h1b;
            default: return 8'h00;
        endcase
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // raws are toggled only with mask and mode settled, so no event is in flight on a change
    initial begin
        void'($urandom(15087));
        repeat (8) @(posedge REF_CLK);
        RST_N <= 1'b1;
        rd(ADDR_TX_IRQ_MASK, 8'h00);
        rd(ADDR_TX_IRQ_MODE, 8'h00);
        rd(ADDR_RX_CTRL_ONE, 8'h00);
        chk({6'h0, RX_XFER_ENABLE, INT_N}, 8'h03);
        for (int i = 0; i < 16; i++) begin
            a = 8'h0b + 8'(i % 4);
            d = (i < 4) ? 8'hff : 8'($urandom);
            wr(a, d);
            rd(a, rd_exp(a, d));
            if (a == ADDR_RX_CTRL_ONE)
                chk({RX_XFER_ENABLE, RX_REF_CLK_SEL}, {~d[4], d[3]});
        end
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_RX_CTRL_ONE, 8'(s));
            repeat (3) begin
                @(posedge REF_CLK);
                LINE_IN <= 4'($urandom);
                step(4);
                chk(RX_CORE_DATA, LINE_IN[s]);
            end
        end
        for (m = 0; m < 5; m++) begin
            wr(ADDR_TX_IRQ_MASK, (m == 4) ? 8'h00 : 8'h03);
            wr(ADDR_TX_IRQ_MODE, (m == 4) ? 8'h00 : 8'({m[1:0], m[1:0]}));
            @(posedge REF_CLK);
            FLAG_CLR <= 1'b1;
            @(posedge REF_CLK);
            FLAG_CLR <= 1'b0;
            SLIP_RAW <= 1'b1;
            XFER_RAW <= 1'b1;
            step(6);
            d = (m == 0 || m == 2) ? 8'h03 : 8'h00;
            chk({SOURCE_SLIP_FLAG, BUFFER_XFER_DONE_FLAG}, d);
            chk(INT_N, d == 8'h00);
            chk(TX_SUMMARY, d != 8'h00);
            // clear while the raws stay high: only level mode sets the flags again
            @(posedge REF_CLK);
            FLAG_CLR <= 1'b1;
            @(posedge REF_CLK);
            FLAG_CLR <= 1'b0;
            step(1);
            chk({SOURCE_SLIP_FLAG, BUFFER_XFER_DONE_FLAG}, (m == 2) ? 8'h03 : 8'h00);
            @(posedge REF_CLK);
            SLIP_RAW <= 1'b0;
            XFER_RAW <= 1'b0;
            step(6);
            chk({SOURCE_SLIP_FLAG, BUFFER_XFER_DONE_FLAG},
                (m == 1 || m == 2) ? 8'h03 : 8'h00);
        end
        end_sim();
    end
endmodule // tb_top
bind tx_irq_mode_rx_input_regs ctl_checker chk_u (.REF_CLK, .RST_N, .WR_EN, .ADDR, .WR_DATA,
    .RD_DATA, .SLIP_RAW, .XFER_RAW, .FLAG_CLR, .RX_REF_CLK_SEL, .RX_XFER_ENABLE,
    .SOURCE_SLIP_FLAG, .BUFFER_XFER_DONE_FLAG, .TX_SUMMARY, .INT_N);
`default_nettype wire
